// file: inc/msps_pkg.sv
// Constants, timing figures and types for the sensor serial port and sleep logic
package msps_pkg;

  // ------------------------------------------------------------------
  // Clock and conversions
  // ------------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 64'd50_000_000;
  localparam longint unsigned NS_PER_S = 64'd1_000_000_000;

  // Least time: round up, never below one cycle
  function automatic int unsigned cyc_up(longint unsigned ns);
    longint unsigned c;
    c = (ns * CLK_HZ + NS_PER_S - 64'd1) / NS_PER_S;
    return (c < 64'd1) ? 1 : int'(c);
  endfunction

  // Longest time: round down, never below one cycle
  function automatic int unsigned cyc_dn(longint unsigned ns);
    longint unsigned c;
    c = (ns * CLK_HZ) / NS_PER_S;
    return (c < 64'd1) ? 1 : int'(c);
  endfunction

  // ------------------------------------------------------------------
  // Timing figures in nanoseconds; sleep entry wait in sensor clocks
  // ------------------------------------------------------------------
  localparam longint unsigned WRITE_TO_WRITE_GAP_NS         = 100_000;
  localparam longint unsigned WRITE_TO_READ_GAP_NS          = 100_000;
  localparam longint unsigned READ_TO_WRITE_GAP_NS          = 250;
  localparam longint unsigned READ_TO_READ_GAP_NS           = 250;
  localparam longint unsigned COMPUTE_NS                    = 3_100_000;
  localparam longint unsigned WAKE_TO_ACCURATE_REPORT_NS    = 50_000_000;
  localparam longint unsigned SUPPLY_UP_TO_REPORT_NS        = 40_000_000;
  localparam longint unsigned SETTLE_NS                     = 610_000;
  localparam longint unsigned TRANSACTION_TIMEOUT_PERIOD_NS = 90_000_000;
  localparam longint unsigned FRAME_PERIOD_NS               = 666_667;
  localparam int unsigned     SLEEP_ENTRY_WAIT_SENSOR_CYC   = 32;

  // ------------------------------------------------------------------
  // Cycle and frame counts
  // ------------------------------------------------------------------
  localparam int unsigned WRITE_TO_WRITE_GAP_CYC = cyc_up(WRITE_TO_WRITE_GAP_NS);
  localparam int unsigned WRITE_TO_READ_GAP_CYC  = cyc_up(WRITE_TO_READ_GAP_NS);
  localparam int unsigned READ_TO_WRITE_GAP_CYC  = cyc_up(READ_TO_WRITE_GAP_NS);
  localparam int unsigned READ_TO_READ_GAP_CYC   = cyc_up(READ_TO_READ_GAP_NS);
  localparam int unsigned COMPUTE_CYC            = cyc_dn(COMPUTE_NS);
  localparam int unsigned WAKE_CAP_CYC           = cyc_dn(WAKE_TO_ACCURATE_REPORT_NS);
  localparam int unsigned SUPPLY_CAP_CYC         = cyc_dn(SUPPLY_UP_TO_REPORT_NS);
  localparam int unsigned SETTLE_CYC             = cyc_up(SETTLE_NS);
  localparam int unsigned TIMEOUT_CYC            = cyc_dn(TRANSACTION_TIMEOUT_PERIOD_NS);
  localparam int unsigned FRAME_CYC              = cyc_up(FRAME_PERIOD_NS);
  localparam int unsigned WAKE_FRAMES            = 75;
  localparam int unsigned SUPPLY_FRAMES          = 50;
  localparam int unsigned LINK_RST_CYC           = 4;

  // ------------------------------------------------------------------
  // Register map and fields
  // ------------------------------------------------------------------
  localparam logic [6:0] CFG_ADDR    = 7'h00;
  localparam logic [6:0] STATUS_ADDR = 7'h01;
  localparam logic [6:0] DX_ADDR     = 7'h02;
  localparam logic [6:0] DY_ADDR     = 7'h03;
  localparam int         SLEEP_BIT   = 6;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [7:0] CFG_SLEEP_MASK = 8'h40;

  typedef enum logic [2:0] {
    ST_UP_SETTLE   = 3'b000,
    ST_UP_FRAMES   = 3'b001,
    ST_RUN         = 3'b010,
    ST_SLEEP       = 3'b011,
    ST_WAKE_SETTLE = 3'b100,
    ST_WAKE_FRAMES = 3'b101
  } msps_state_type;

endpackage

// file: rtl/msps_sensor_port.sv
// Serial register port with transaction timeout, sleep entry and wake-up sequencing

// Function
// (R1) Host waits 100 us between writes
// (R2) Host waits 100 us from write to read
// (R3) Host waits 250 ns from read to write
// (R4) Host waits 250 ns between reads
// (R5) Image results valid within 3.1 ms of wake
// (R6) Motion in sleep: up to 75 settling frames
// (R7) Host waits 32 sensor clocks after sleep write
// (R8) Accurate reports within 50 ms of wake
// (R9) Accurate reports within 40 ms of power-up
// (R10) Unfinished transaction resets port after timeout
// (R11) Config bit 6 enters and leaves sleep
// (R12) In sleep only bit 6 is written
// (R13) No timeout during sleep; host sends whole commands
// (R14) Register settings kept through sleep
// (R15) Frame rate at most 1500 per second
module msps_sensor_port
  import msps_pkg::*;
#(
  parameter int unsigned COMPUTE_CYC_P  = COMPUTE_CYC,
  parameter int unsigned WAKE_CAP_CYC_P = WAKE_CAP_CYC,
  parameter int unsigned UP_CAP_CYC_P   = SUPPLY_CAP_CYC,
  parameter int unsigned SETTLE_CYC_P   = SETTLE_CYC,
  parameter int unsigned TIMEOUT_CYC_P  = TIMEOUT_CYC,
  parameter int unsigned FRAME_CYC_P    = FRAME_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       sclk_i,
  input  wire logic       sdio_i,
  output logic            sdio_o,
  output logic            sdio_oe_o,
  input  wire logic       motion_i,
  input  wire logic [7:0] delta_x_i,
  input  wire logic [7:0] delta_y_i,
  output logic [7:0]      config_o,
  output logic            sleep_state_o,
  output logic            image_valid_o,
  output logic            report_accurate_o,
  output logic            frame_tick_o
);

  // ------------------------------------------------------------------
  // Link side (serial clock domain)
  // ------------------------------------------------------------------
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, wdat_q, wdat_d;
  logic [6:0] addr_q, addr_d;
  logic       is_wr_q, is_wr_d, wr_tgl_q, wr_tgl_d, rd_tgl_q, rd_tgl_d;
  logic       busy_q, sl_l1_q, sl_l2_q;
  logic       out_q, out_d, oe_q, oe_d;
  logic       link_rst_q;
  logic [7:0] rd_hold_q;

  always_comb begin
    cnt_d    = cnt_q + 4'h1;
    sh_d     = {sh_q[6:0], sdio_i};
    addr_d   = addr_q;
    is_wr_d  = is_wr_q;
    wdat_d   = wdat_q;
    wr_tgl_d = wr_tgl_q;
    rd_tgl_d = rd_tgl_q;
    if (cnt_q == 4'h7) begin
      addr_d  = sh_d[6:0];
      is_wr_d = sh_d[7];
      if (!sh_d[7]) begin
        rd_tgl_d = ~rd_tgl_q;
      end
    end
    if (cnt_q == 4'hf && is_wr_q) begin
      wdat_d   = sh_d;
      wr_tgl_d = ~wr_tgl_q;
    end
  end

  // Timeout reset or system reset is the only way out of a half-sent command
  always_ff @(posedge sclk_i or posedge link_rst_q) begin
    if (link_rst_q) begin
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      addr_q   <= 7'h00;
      is_wr_q  <= 1'b0;
      wdat_q   <= 8'h00;
      wr_tgl_q <= 1'b0;
      rd_tgl_q <= 1'b0;
      busy_q   <= 1'b0;
      sl_l1_q  <= 1'b0;
      sl_l2_q  <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      addr_q   <= addr_d;
      is_wr_q  <= is_wr_d;
      wdat_q   <= wdat_d;
      wr_tgl_q <= wr_tgl_d;
      rd_tgl_q <= rd_tgl_d;
      busy_q   <= (cnt_d != 4'h0);
      sl_l1_q  <= config_o[SLEEP_BIT];
      sl_l2_q  <= sl_l1_q;
    end
  end

  // Read data launched on falling edges; pin released while asleep
  always_comb begin
    oe_d  = 1'b0;
    out_d = 1'b0;
    if (!sl_l2_q && !is_wr_q && cnt_q[3]) begin
      oe_d  = 1'b1;
      out_d = rd_hold_q[~cnt_q[2:0]];
    end
  end

  always_ff @(negedge sclk_i or posedge link_rst_q) begin
    if (link_rst_q) begin
      out_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  assign sdio_o    = out_q;
  assign sdio_oe_o = oe_q;

  // ------------------------------------------------------------------
  // Crossing into the system clock domain
  // ------------------------------------------------------------------
  logic wr_s1_q, wr_s2_q, wr_s3_q, rd_s1_q, rd_s2_q, rd_s3_q;
  logic bz_s1_q, bz_s2_q, mo_s1_q, mo_s2_q;
  logic wr_evt, rd_evt;

  always_ff @(posedge clk_i) begin
    wr_s1_q <= wr_tgl_q;
    wr_s2_q <= wr_s1_q;
    wr_s3_q <= wr_s2_q;
    rd_s1_q <= rd_tgl_q;
    rd_s2_q <= rd_s1_q;
    rd_s3_q <= rd_s2_q;
    bz_s1_q <= busy_q;
    bz_s2_q <= bz_s1_q;
    mo_s1_q <= motion_i;
    mo_s2_q <= mo_s1_q;
  end

  // Address and data words are stable here because of host spacing
  assign wr_evt = wr_s2_q ^ wr_s3_q;  // [R1] [R2]
  assign rd_evt = rd_s2_q ^ rd_s3_q;  // [R3] [R4]

  // ------------------------------------------------------------------
  // Registers, timeout and wake sequencing
  // ------------------------------------------------------------------
  msps_state_type st_q, st_d;
  logic [7:0]  cfg_q, cfg_d, dx_q, dx_d, dy_q, dy_d, rdh_d;
  logic [31:0] ela_q, ela_d, fr_q, fr_d, to_q, to_d;
  logic [6:0]  nfr_q, nfr_d, need_q, need_d;
  logic [2:0]  lr_q, lr_d;
  logic        iv_q, iv_d, acc_q, acc_d, moved_q, moved_d, tick_q, tick_d;
  logic        fr_run, tick;
  logic        slp_q, slp_d;

  function automatic logic [7:0] reg_read(logic [6:0] a, logic [7:0] c, logic [3:0] s,
                                          logic [7:0] x, logic [7:0] y);
    unique case (a)
      CFG_ADDR:    return c;
      STATUS_ADDR: return {4'h0, s};
      DX_ADDR:     return x;
      DY_ADDR:     return y;
      default:     return 8'h00;
    endcase
  endfunction

  assign fr_run = (st_q == ST_RUN) || (st_q == ST_UP_FRAMES) || (st_q == ST_WAKE_FRAMES);
  assign tick   = fr_run && (fr_q == FRAME_CYC_P - 1);  // [R15]

  always_comb begin
    st_d    = st_q;
    cfg_d   = cfg_q;
    dx_d    = dx_q;
    dy_d    = dy_q;
    rdh_d   = rd_hold_q;
    ela_d   = ela_q + 32'h0000_0001;
    fr_d    = (fr_run && !tick) ? fr_q + 32'h0000_0001 : 32'h0000_0000;
    nfr_d   = nfr_q;
    need_d  = need_q;
    iv_d    = iv_q;
    acc_d   = acc_q;
    moved_d = moved_q;
    tick_d  = tick;
    to_d    = 32'h0000_0000;
    lr_d    = (lr_q != 3'h0) ? lr_q - 3'h1 : 3'h0;
    if (bz_s2_q && !cfg_q[SLEEP_BIT]) begin  // [R13]
      to_d = to_q + 32'h0000_0001;
      if (to_q == TIMEOUT_CYC_P - 1) begin  // [R10]
        to_d = 32'h0000_0000;
        lr_d = 3'(LINK_RST_CYC);
      end
    end
    if (rd_evt) begin
      rdh_d = reg_read(addr_q, cfg_q, {moved_q, acc_q, iv_q, cfg_q[SLEEP_BIT]}, dx_q, dy_q);
    end
    if (wr_evt && addr_q == CFG_ADDR) begin
      if (cfg_q[SLEEP_BIT]) begin
        cfg_d = (cfg_q & ~CFG_SLEEP_MASK) | (wdat_q & CFG_SLEEP_MASK);  // [R12] [R14]
      end else begin
        cfg_d = wdat_q;  // [R11]
      end
    end
    if (tick) begin
      dx_d  = delta_x_i;
      dy_d  = delta_y_i;
      nfr_d = nfr_q + 7'h01;
    end
    unique case (st_q)
      ST_UP_SETTLE, ST_WAKE_SETTLE: begin
        if (ela_q >= SETTLE_CYC_P - 1) begin
          st_d  = (st_q == ST_UP_SETTLE) ? ST_UP_FRAMES : ST_WAKE_FRAMES;
          nfr_d = 7'h00;
        end
      end
      ST_UP_FRAMES, ST_WAKE_FRAMES: begin
        if (tick) begin
          iv_d = 1'b1;  // [R5]
        end
        if (st_q == ST_WAKE_FRAMES && ela_q >= COMPUTE_CYC_P - 1) begin
          iv_d = 1'b1;  // [R5]
        end
        if ((tick && nfr_q + 7'h01 >= need_q) ||
            (st_q == ST_WAKE_FRAMES && ela_q >= WAKE_CAP_CYC_P - 1) ||  // [R8]
            (st_q == ST_UP_FRAMES && ela_q >= UP_CAP_CYC_P - 1)) begin  // [R9]
          st_d    = ST_RUN;
          acc_d   = 1'b1;
          iv_d    = 1'b1;
          moved_d = 1'b0;
        end
      end
      ST_RUN: begin
        ela_d = ela_q;
      end
      ST_SLEEP: begin
        ela_d = 32'h0000_0000;
        if (mo_s2_q) begin
          moved_d = 1'b1;  // [R6]
        end
        if (!cfg_q[SLEEP_BIT]) begin  // [R11]
          st_d   = ST_WAKE_SETTLE;
          need_d = moved_q ? 7'(WAKE_FRAMES) : 7'h01;  // [R6]
        end
      end
      default: begin
        st_d = ST_UP_SETTLE;
      end
    endcase
    // Sleep clears the image-valid and accurate flags; held registers stay as they are
    if (cfg_q[SLEEP_BIT] && st_q != ST_SLEEP) begin  // [R11] [R7]
      st_d  = ST_SLEEP;
      iv_d  = 1'b0;
      acc_d = 1'b0;
      dx_d  = dx_q;
      dy_d  = dy_q;
    end
    slp_d = (st_d == ST_SLEEP);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_q       <= ST_UP_SETTLE;
      cfg_q      <= CFG_RESET;
      dx_q       <= 8'h00;
      dy_q       <= 8'h00;
      rd_hold_q  <= 8'h00;
      ela_q      <= 32'h0000_0000;
      fr_q       <= 32'h0000_0000;
      to_q       <= 32'h0000_0000;
      nfr_q      <= 7'h00;
      need_q     <= 7'(SUPPLY_FRAMES);  // [R9]
      iv_q       <= 1'b0;
      acc_q      <= 1'b0;
      moved_q    <= 1'b0;
      tick_q     <= 1'b0;
      lr_q       <= 3'(LINK_RST_CYC);
      link_rst_q <= 1'b1;
      slp_q      <= 1'b0;
    end else begin
      st_q       <= st_d;
      cfg_q      <= cfg_d;
      dx_q       <= dx_d;
      dy_q       <= dy_d;
      rd_hold_q  <= rdh_d;
      ela_q      <= ela_d;
      fr_q       <= fr_d;
      to_q       <= to_d;
      nfr_q      <= nfr_d;
      need_q     <= need_d;
      iv_q       <= iv_d;
      acc_q      <= acc_d;
      moved_q    <= moved_d;
      tick_q     <= tick_d;
      lr_q       <= lr_d;
      link_rst_q <= (lr_d != 3'h0);
      slp_q      <= slp_d;
    end
  end

  assign config_o          = cfg_q;
  assign sleep_state_o     = slp_q;
  assign image_valid_o     = iv_q;
  assign report_accurate_o = acc_q;
  assign frame_tick_o      = tick_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_timeout_fires;
    (bz_s2_q && !cfg_q[SLEEP_BIT] && to_q == TIMEOUT_CYC_P - 1) |=> link_rst_q [*2];
  endproperty
  a_timeout_fires: assert property (p_timeout_fires) else $error("timeout missed"); // [R10]

  property p_no_timeout_asleep;
    cfg_q[SLEEP_BIT] |=> (to_q == 32'h0000_0000);
  endproperty
  a_no_timeout_asleep: assert property (p_no_timeout_asleep) else $error("timer ran"); // [R13]

  property p_sleep_enter;
    (wr_evt && addr_q == CFG_ADDR && wdat_q[SLEEP_BIT]) |=> ##1 sleep_state_o;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("no sleep"); // [R11]

  property p_sleep_cfg_held;
    (cfg_q[SLEEP_BIT] && wr_evt && addr_q == CFG_ADDR) |=>
      ((cfg_q & ~CFG_SLEEP_MASK) == ($past(cfg_q) & ~CFG_SLEEP_MASK));
  endproperty
  a_sleep_cfg_held: assert property (p_sleep_cfg_held) else $error("cfg changed"); // [R12]

  property p_regs_kept;
    sleep_state_o |=> ($stable(dx_q) && $stable(dy_q));
  endproperty
  a_regs_kept: assert property (p_regs_kept) else $error("regs changed"); // [R14]

  property p_compute;
    (st_q == ST_WAKE_FRAMES && ela_q >= COMPUTE_CYC_P) |-> iv_q;
  endproperty
  a_compute: assert property (p_compute) else $error("image late"); // [R5]

  property p_wake_cap;
    (st_q == ST_WAKE_FRAMES && ela_q >= WAKE_CAP_CYC_P) |-> 1'b0;
  endproperty
  a_wake_cap: assert property (p_wake_cap) else $error("wake report late"); // [R8]

  property p_up_cap;
    (st_q == ST_UP_FRAMES && ela_q >= UP_CAP_CYC_P) |-> 1'b0;
  endproperty
  a_up_cap: assert property (p_up_cap) else $error("power-up report late"); // [R9]

  property p_moved_frames;
    (st_q == ST_WAKE_FRAMES && !$rose(acc_q) && moved_q && nfr_q < 7'(WAKE_FRAMES - 1)
     && ela_q < WAKE_CAP_CYC_P - 1) |=> !acc_q;
  endproperty
  a_moved_frames: assert property (p_moved_frames) else $error("early accurate"); // [R6]

  property p_frame_rate;
    tick_q |=> !tick_q [*2];
  endproperty
  a_frame_rate: assert property (p_frame_rate) else $error("frames too fast"); // [R15]

  c_wake:    cover property (st_q == ST_SLEEP ##1 st_q == ST_WAKE_SETTLE);
  c_timeout: cover property ($rose(link_rst_q));
  c_read:    cover property (rd_evt && addr_q == STATUS_ADDR);
  c_moved:   cover property (moved_q && st_q == ST_WAKE_FRAMES);

endmodule

// file: sim/msps_host_model.sv
// Host side of the two-wire port: bit-level driver with command spacing
module msps_host_model (
  input  wire logic sdio_o,
  input  wire logic sdio_oe_o,
  output logic      sclk_o,
  output logic      sdio_wire_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic drv_en;
  logic drv_bit;
  logic last_bit;
  logic asleep;

  // Released line shows the inverse of the last host bit, never a stale copy
  assign sdio_wire_o = sdio_oe_o ? sdio_o : (drv_en ? drv_bit : ~last_bit);

  initial begin
    sclk_o   = 1'b0;
    drv_en   = 1'b0;
    drv_bit  = 1'b0;
    last_bit = 1'b0;
    asleep   = 1'b0;
  end

  // ------------------------------------------------------------------
  // Bit shifting, MSB first; clock stands low outside commands
  // ------------------------------------------------------------------
  task automatic send_bits(input logic [15:0] w, input int n);
    for (int i = 15; i > 15 - n; i--) begin
      drv_en  = 1'b1;
      drv_bit = w[i];
      #7.5 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
    end
    last_bit = drv_bit;
    drv_en   = 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    send_bits({1'b1, a, d}, 16);
    if (a == 7'h00) asleep = d[6];
    #100000; // Full write gap, also covers the sleep entry wait
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    send_bits({1'b0, a, 8'h00}, 7);
    drv_en  = 1'b1;
    drv_bit = a[0];
    #7.5 sclk_o = 1'b1;
    #7.5 drv_en = 1'b0;
    last_bit = a[0];
    #200 sclk_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #7.5 sclk_o = 1'b1;
      d[i] = sdio_wire_o;
      #7.5 sclk_o = 1'b0;
    end
    #250; // Read gap before any next command
  endtask

  // Broken command, only while awake since sleep has no timeout
  task automatic partial(input int n);
    if (!asleep) send_bits(16'h8000, n);
  endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the sensor serial port and sleep sequencing
module tb_top import msps_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int FRM  = 20;
  localparam int SET  = 50;
  localparam int CMP  = 300;
  localparam int WCAP = 3000;
  localparam int UCAP = 2500;
  localparam int TMO  = 400;

  typedef struct packed {
    logic       wr;
    logic [6:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } msps_tbrow_type;

  localparam msps_tbrow_type ROWS [5] = '{
    '{1'b1, 7'h00, 8'h03, 8'h03}, '{1'b0, 7'h02, 8'h00, 8'hA5},
    '{1'b0, 7'h03, 8'h00, 8'h5A}, '{1'b0, 7'h7F, 8'h00, 8'h00},
    '{1'b1, 7'h02, 8'h77, 8'hA5}};

  logic       clk;
  logic       rst_b;
  logic       sclk;
  logic       sdio;
  logic       sdio_o;
  logic       sdio_oe;
  logic       motion;
  logic [7:0] dx;
  logic [7:0] dy;
  logic [7:0] cfg;
  logic       slp;
  logic       imgv;
  logic       acc;
  logic       ftick;
  logic [7:0] rv;
  int         n_fail     = 0;
  int         num_checks = 0;
  int         gap        = 0;
  logic       seen       = 1'b0;
  int         n1;
  int         n2;

  msps_sensor_port #(.COMPUTE_CYC_P(CMP), .WAKE_CAP_CYC_P(WCAP), .UP_CAP_CYC_P(UCAP),
    .SETTLE_CYC_P(SET), .TIMEOUT_CYC_P(TMO), .FRAME_CYC_P(FRM)) dut_u (
    .clk_i(clk), .rst_b_i(rst_b), .sclk_i(sclk), .sdio_i(sdio), .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe), .motion_i(motion), .delta_x_i(dx), .delta_y_i(dy),
    .config_o(cfg), .sleep_state_o(slp), .image_valid_o(imgv),
    .report_accurate_o(acc), .frame_tick_o(ftick));

  msps_host_model host_u (.sdio_o(sdio_o), .sdio_oe_o(sdio_oe), .sclk_o(sclk),
    .sdio_wire_o(sdio));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Shared checks and waits
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic flag(input int s);
    case (s)
      0: return acc;
      1: return imgv;
      default: return slp;
    endcase
  endfunction

  // Bounded wait; then compares the flag against the expected level itself
  task automatic wait_flag(input int s, input logic lv, input int lim, output int n);
    n = 0;
    while (flag(s) !== lv && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h0, flag(s)}, {7'h0, lv});
  endtask

  task automatic wake_chk(input logic [7:0] d, input int min_acc, input int max_acc);
    fork
      host_u.wr(CFG_ADDR, d);
      begin
        wait_flag(2, 1'b0, 100, n1);
        wait_flag(1, 1'b1, CMP, n1);
        wait_flag(0, 1'b1, WCAP - n1, n2);
        chk({7'h0, (n1 + n2) >= min_acc && (n1 + n2) <= max_acc}, 8'h01);
      end
    join
    $display("test wake done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Frame spacing never shorter than the frame period
  always @(negedge clk) begin
    if (ftick === 1'b1) begin
      num_checks++;
      if (seen && gap < FRM) begin
        n_fail++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, gap, FRM);
      end
      seen = 1'b1;
      gap  = 1;
    end else begin
      gap++;
    end
  end

  initial begin
    #1_500_000;
    n_fail++;
    wrap_up();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    rst_b  = 1'b0;
    motion = 1'b0;
    dx     = 8'hA5;
    dy     = 8'h5A;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    chk(cfg, CFG_RESET);
    chk({6'h0, slp, sdio_oe}, 8'h00);
    repeat (6) @(posedge clk);
    wait_flag(0, 1'b1, UCAP, n1);
    chk({7'h0, n1 > 900}, 8'h01);
    $display("test power_up done");
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) host_u.wr(ROWS[i].a, ROWS[i].d);
      host_u.rd(ROWS[i].a, rv);
      chk(rv, ROWS[i].e);
      chk({7'h0, sdio_oe}, 8'h00);
    end
    $display("test table done");
    host_u.partial(5);
    repeat (TMO + 20) @(posedge clk);
    host_u.wr(CFG_ADDR, 8'h0C);
    chk(cfg, 8'h0C);
    $display("test timeout done");
    host_u.wr(CFG_ADDR, 8'h4C);
    chk({cfg[6], slp, sdio_oe}, 3'b110);
    @(posedge clk);
    #1 motion = 1'b1;
    host_u.wr(CFG_ADDR, 8'h73);
    chk(cfg, 8'h4C);
    #1 motion = 1'b0;
    wake_chk(8'h33, 1000, WCAP);
    chk(cfg, 8'h0C);
    host_u.rd(DX_ADDR, rv);
    chk(rv, 8'hA5);
    host_u.wr(CFG_ADDR, 8'h4C);
    wake_chk(8'h0C, 0, 200);
    wrap_up();
  end
endmodule
